// file: rtl/rms_ref_monitor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - each input's predivider can be bypassed, passing raw edges through
// - per PLL priority order; automatic mode takes highest available input
// - up to three ordered spares follow the primary input
// - manual mode forces one input without spares; fewer spares allowed
// - default switching absorbs phase difference (phase build-out)
// - phase propagation mode, by loop bandwidth or 10/40/160 us/s slope
// - optional frequency ramp 0.2/2/20/40000 ppm/s on switching
// - live active-high status bit per defect, high only during it
// - sticky notify bit per defect, held until software clears
// - each notify bit individually enabled; disabled ones not captured
// - each flex pin shows OR of a selected set of notify bits
// - selected notify bits drive the active-low fault interrupt
// - input monitors observe the predivided clock
// - input loss asserts after set-edge count of consecutive missing edges
// - clear condition: fewer consecutive missing edges than clear-edge count
// - loss deasserts after clear held for validation wait; violation restarts
// - lock loss asserts when ref/feedback error exceeds set threshold
// - independent clear threshold gives hysteresis
// - lock loss held until settling timer expires after clearing
// - lock loss goes to status, notify and flex pins
// - all configured references lost puts PLL in holdover
// - drift defects may be ORed with clock loss for switching
module rms_ref_monitor
    import rms_pkg::*;
#(
    parameter int NUM_FLEX  = 4,
    parameter int VAL_CYC_0 = VAL_MS_0 * CLK_KHZ,
    parameter int VAL_CYC_1 = VAL_MS_1 * CLK_KHZ,
    parameter int VAL_CYC_2 = VAL_MS_2 * CLK_KHZ,
    parameter int VAL_CYC_3 = VAL_MS_3 * CLK_KHZ
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     resetn_in,
    input  wire logic [NUM_IN-1:0]        ref_clk_in,       // sampled input clock levels
    input  wire rms_in_cfg_t [NUM_IN-1:0] in_cfg_in,
    input  wire logic [NUM_IN-1:0]        freq_drift_flag_in,
    input  wire rms_pll_cfg_t [NUM_PLL-1:0] pll_cfg_in,
    input  wire logic [NUM_PLL-1:0][15:0] freq_err_in,      // |ref-fb| in 0.1 ppm
    input  wire logic [NUM_DEF-1:0]       notify_en_in,
    input  wire logic [NUM_DEF-1:0]       notify_clr_in,    // write-one-to-clear pulse
    input  wire logic [NUM_FLEX-1:0][NUM_DEF-1:0] flex_mask_in,
    input  wire logic [NUM_DEF-1:0]       irq_mask_in,
    output logic [NUM_IN-1:0]             prediv_pulse_out, // predivided reference edge
    output logic [NUM_DEF-1:0]            status_out,
    output logic [NUM_DEF-1:0]            notify_out,
    output logic [NUM_FLEX-1:0]           flex_pin_out,
    output logic                          fault_irq_n_out,
    output logic [NUM_PLL-1:0][1:0]       sel_out,
    output logic [NUM_PLL-1:0]            holdover_out,
    output logic [NUM_PLL-1:0]            switch_pulse_out,
    output rms_sw_t [NUM_PLL-1:0]         sw_ctrl_out
);
    // ****************************************
    // input monitors
    // ****************************************
    logic [NUM_IN-1:0]  ref_prev;
    logic [NUM_IN-1:0]  input_loss_flag;
    logic [NUM_IN-1:0]  in_unavail;
    logic [NUM_PLL-1:0] lock_loss_flag;

    genvar k;
    generate
        for (k = 0; k < NUM_IN; k++) begin : g_in
            // per-input state, all timed on the system clock
            logic [15:0] div_cnt;
            logic [23:0] per_cnt;
            logic [7:0]  miss_cnt;
            logic [31:0] val_cnt;
            logic [31:0] val_lim;
            logic        rise;
            logic        edge_ok;
            logic        clr_ok;

            // rising edge of the sampled pin level
            assign rise    = ref_clk_in[k] & ~ref_prev[k];
            // bypass or ratio 0/1 passes every raw edge
            // else the div-th raw edge is the predivided edge;
            // the count restarts on it, so the rate is raw over div
            assign edge_ok = rise & (in_cfg_in[k].bypass || in_cfg_in[k].div <= 16'h0001 ||
                             div_cnt >= in_cfg_in[k].div - 16'h0001);
            // clear bound apart from set bound gives hysteresis
            assign clr_ok  = miss_cnt < in_cfg_in[k].clr_edges;
            // what selectors skip: loss, or drift when asked
            // drift never enters the live loss flag itself
            assign in_unavail[k] = input_loss_flag[k] |
                                   (in_cfg_in[k].drift_or & freq_drift_flag_in[k]);

            // validation wait length in system cycles
            // parameters, so a bench can shrink them;
            // the real waits run to 1e8 cycles
            always_comb begin
                case (in_cfg_in[k].val_sel)
                    2'h0:    val_lim = VAL_CYC_0;
                    2'h1:    val_lim = VAL_CYC_1;
                    2'h2:    val_lim = VAL_CYC_2;
                    default: val_lim = VAL_CYC_3;
                endcase
            end

            // predivider edge counter
            // last level resets low: a pin high at release
            // reads as one rising edge, counted like any other
            // pulse is registered, one edge after the high level
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ref_prev[k]         <= 1'b0;
                    div_cnt             <= 16'h0000;
                    prediv_pulse_out[k] <= 1'b0;
                end else begin
                    ref_prev[k]         <= ref_clk_in[k];
                    prediv_pulse_out[k] <= edge_ok;
                    if (edge_ok) begin
                        div_cnt <= 16'h0000;
                    end else if (rise) begin
                        div_cnt <= div_cnt + 16'h0001;
                    end
                end
            end

            // missing-edge count timed on the system clock
            // a full expected period with no edge is one miss
            // per_cnt restarts at each miss, one period apart
            // saturates so a dead input never wraps to clear
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    per_cnt  <= 24'h000000;
                    miss_cnt <= 8'h00;
                end else if (edge_ok) begin
                    per_cnt  <= 24'h000000;
                    miss_cnt <= 8'h00;
                end else if (per_cnt + 24'h000001 >= in_cfg_in[k].period) begin
                    per_cnt  <= 24'h000000;
                    if (miss_cnt != 8'hff) begin
                        miss_cnt <= miss_cnt + 8'h01;
                    end
                end else begin
                    per_cnt <= per_cnt + 24'h000001;
                end
            end

            // loss flag with validation wait
            // set wins over the wait, so a relapse restarts it;
            // a miss at or above the clear bound restarts it
            // as well
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    input_loss_flag[k] <= 1'b0;
                    val_cnt            <= 32'h00000000;
                end else if (miss_cnt >= in_cfg_in[k].set_edges) begin
                    input_loss_flag[k] <= 1'b1;
                    val_cnt            <= 32'h00000000;
                end else if (input_loss_flag[k]) begin
                    if (!clr_ok) begin
                        val_cnt <= 32'h00000000;
                    end else if (val_cnt + 32'h00000001 >= val_lim) begin
                        input_loss_flag[k] <= 1'b0;
                        val_cnt            <= 32'h00000000;
                    end else begin
                        val_cnt <= val_cnt + 32'h00000001;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // lock-loss monitors and selectors per PLL
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < NUM_PLL; p++) begin : g_pll
            logic [31:0] settle_cnt;
            logic [15:0] set_thr;
            logic [15:0] clr_thr;
            logic [1:0]  next_sel;
            logic        next_hold;
            logic        sw_evt;

            // thresholds from fixed tables in 0.1 ppm steps
            // a set choice past the table takes the widest
            assign set_thr = (pll_cfg_in[p].ll_set_sel > 4'h9) ? LL_SET_TBL[9] :
                             LL_SET_TBL[pll_cfg_in[p].ll_set_sel];
            assign clr_thr = LL_CLR_TBL[pll_cfg_in[p].ll_clr_sel];

            // lock loss with settling delay before release
            // error above set raises the flag; below clear
            // starts settling; in between the flag holds
            // release after settle_cyc plus one clean cycles
            // a renewed error restarts the settling count
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    lock_loss_flag[p] <= 1'b0;
                    settle_cnt        <= 32'h00000000;
                end else if (freq_err_in[p] > set_thr) begin
                    lock_loss_flag[p] <= 1'b1;
                    settle_cnt        <= 32'h00000000;
                end else if (lock_loss_flag[p]) begin
                    if (freq_err_in[p] >= clr_thr) begin
                        settle_cnt <= 32'h00000000;
                    end else if (settle_cnt >= pll_cfg_in[p].settle_cyc) begin
                        lock_loss_flag[p] <= 1'b0;
                        settle_cnt        <= 32'h00000000;
                    end else begin
                        settle_cnt <= settle_cnt + 32'h00000001;
                    end
                end
            end

            // first available entry of the priority list, else holdover
            // scan from the highest entry down: the lowest
            // available one wins; entries past num_spare ignored
            // nothing available: the last choice is held; once
            // an entry returns, the first available one is taken
            // a lost forced input also reports holdover
            always_comb begin
                next_sel  = sel_out[p];
                next_hold = 1'b1;
                if (pll_cfg_in[p].manual) begin
                    next_sel  = pll_cfg_in[p].man_sel;
                    next_hold = in_unavail[pll_cfg_in[p].man_sel];
                end else begin
                    for (int i = NUM_IN - 1; i >= 0; i--) begin
                        if (i <= int'(pll_cfg_in[p].num_spare) &&
                            !in_unavail[pll_cfg_in[p].prio[2*i +: 2]]) begin
                            next_sel  = pll_cfg_in[p].prio[2*i +: 2];
                            next_hold = 1'b0;
                        end
                    end
                end
            end

            // a switch is a new input or the end of holdover
            assign sw_evt = (next_sel != sel_out[p]) | (holdover_out[p] & ~next_hold);

            // selection, holdover and switching style
            // style latched only at a switch, so a settings
            // change never disturbs a reference in use
            // reset leaves phase build-out with no ramp
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    sel_out[p]          <= SEL_RST;
                    holdover_out[p]     <= 1'b1;
                    switch_pulse_out[p] <= 1'b0;
                    sw_ctrl_out[p]      <= '0;
                end else begin
                    sel_out[p]          <= next_sel;
                    holdover_out[p]     <= next_hold;
                    switch_pulse_out[p] <= sw_evt;
                    if (sw_evt) begin
                        sw_ctrl_out[p] <= pll_cfg_in[p].sw;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // status, notify, flex pins, interrupt
    // ****************************************
    logic [NUM_DEF-1:0] defects;
    logic [NUM_DEF-1:0] next_notify;

    // input loss on bits 0..3, lock loss on bits 4..7
    assign defects     = {lock_loss_flag, input_loss_flag};
    // set wins over a clear in the same cycle
    // a clear while the defect persists keeps the bit,
    // so software still sees it on the next read
    // disabled bits are never captured
    assign next_notify = (notify_out & ~notify_clr_in) | (defects & notify_en_in);

    // live status, sticky notify and the interrupt pin
    // pins use next_notify, so they move on the same
    // edge as the notify bits they report
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_out      <= MASK_RST;
            notify_out      <= MASK_RST;
            fault_irq_n_out <= 1'b1;
        end else begin
            status_out      <= defects;
            notify_out      <= next_notify;
            fault_irq_n_out <= ~|(next_notify & irq_mask_in);
        end
    end

    // one or-reduction per flex pin over its own mask
    genvar f;
    generate
        for (f = 0; f < NUM_FLEX; f++) begin : g_flex
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    flex_pin_out[f] <= 1'b0;
                end else begin
                    flex_pin_out[f] <= |(next_notify & flex_mask_in[f]);
                end
            end
        end
    endgenerate
endmodule

// file: rtl/rms_pkg.sv
package rms_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_IN    = 4;
    localparam int NUM_PLL   = 4;
    localparam int NUM_DEF   = 2 * NUM_IN;   // input loss 0..3, lock loss 4..7
    localparam int CLK_KHZ   = 100000;       // system clock rate in kHz
    // ****************************************
    // validation wait choices, in ms
    // ****************************************
    localparam int VAL_MS_0  = 2;
    localparam int VAL_MS_1  = 100;
    localparam int VAL_MS_2  = 200;
    localparam int VAL_MS_3  = 1000;
    // ****************************************
    // lock-loss thresholds in units of 0.1 ppm
    // ****************************************
    localparam logic [15:0] LL_SET_TBL [10] = '{16'h0002, 16'h0004, 16'h0014, 16'h0028,
        16'h00c8, 16'h0190, 16'h07d0, 16'h0fa0, 16'h4e20, 16'h9c40};
    localparam logic [15:0] LL_CLR_TBL [4]  = '{16'h0002, 16'h0004, 16'h0014, 16'h07d0};
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] SEL_RST   = 2'h0;
    localparam logic [7:0] MASK_RST  = 8'h00;
    // switching slope codes: 10/40/160 us/s and 0.2/2/20/40000 ppm/s
    typedef enum logic [1:0] {RMS_PS_10, RMS_PS_40, RMS_PS_160, RMS_PS_BW} rms_pslope_t;
    typedef enum logic [1:0] {RMS_FR_0P2, RMS_FR_2, RMS_FR_20, RMS_FR_40K} rms_fslope_t;
    typedef struct packed {
        logic        bypass;     // predivider bypass
        logic [15:0] div;        // predivide ratio
        logic [23:0] period;     // expected predivided period, system cycles
        logic [7:0]  set_edges;  // missing edges to declare loss
        logic [7:0]  clr_edges;  // missing-edge bound for clear
        logic [1:0]  val_sel;    // validation wait choice
        logic        drift_or;   // drift also makes input unavailable
    } rms_in_cfg_t;
    typedef struct packed {
        logic         phase_prop;
        rms_pslope_t  prop_slope;
        logic         ramp_en;
        rms_fslope_t  ramp_slope;
    } rms_sw_t;
    typedef struct packed {
        logic        manual;
        logic [1:0]  man_sel;
        logic [7:0]  prio;       // four 2-bit entries, entry 0 first
        logic [1:0]  num_spare;  // spares after entry 0
        rms_sw_t     sw;
        logic [3:0]  ll_set_sel;
        logic [1:0]  ll_clr_sel;
        logic [31:0] settle_cyc;
    } rms_pll_cfg_t;
endpackage

// file: verification/rms_ref_src.sv
`timescale 1ns/1ps
// ****************************************
// upstream clock sources and host clears
// ****************************************
module rms_ref_src
    import rms_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic [NUM_IN-1:0]  run_in,
    input  wire logic [NUM_DEF-1:0] clr_req_in,
    output logic [NUM_IN-1:0]       ref_clk_out = '0,
    output logic [NUM_DEF-1:0]      notify_clr_out = '0
);
    logic [2:0]         phase = '0;
    logic [NUM_DEF-1:0] req_q = '0;
    // eight-cycle clocks, a stopped source parks low; one clear pulse per write
    always @(posedge clk_in) begin
        phase <= phase + 3'h1;
        ref_clk_out <= {NUM_IN{phase < 3'h4}} & run_in;
        notify_clr_out <= clr_req_in & ~req_q;
        req_q <= clr_req_in;
    end
endmodule

// file: verification/rms_ref_watch_monitor.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module rms_ref_watch
    import rms_pkg::*;
#(
    parameter int NUM_FLEX = 4
) (
    input wire logic                             clk_sys_in,
    input wire logic                             resetn_in,
    input wire rms_pll_cfg_t [NUM_PLL-1:0]       pll_cfg_in,
    input wire logic [NUM_PLL-1:0][15:0]         freq_err_in,
    input wire logic [NUM_DEF-1:0]               notify_en_in,
    input wire logic [NUM_DEF-1:0]               notify_clr_in,
    input wire logic [NUM_FLEX-1:0][NUM_DEF-1:0] flex_mask_in,
    input wire logic [NUM_DEF-1:0]               irq_mask_in,
    input wire logic [NUM_DEF-1:0]               status_out,
    input wire logic [NUM_DEF-1:0]               notify_out,
    input wire logic [NUM_FLEX-1:0]              flex_pin_out,
    input wire logic                             fault_irq_n_out,
    input wire logic [NUM_PLL-1:0][1:0]          sel_out,
    input wire logic [NUM_PLL-1:0]               holdover_out,
    input wire logic [NUM_PLL-1:0]               switch_pulse_out
);
    logic [NUM_FLEX-1:0][NUM_DEF-1:0] fmask_q;
    logic [NUM_DEF-1:0]               imask_q;
    logic [NUM_FLEX-1:0]              flex_exp;
    logic [15:0]                      set_thr;
    // masks as the design used them at the last edge
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fmask_q <= '0;
            imask_q <= '0;
        end else begin
            fmask_q <= flex_mask_in;
            imask_q <= irq_mask_in;
        end
    end
    // expected flex pins and pll 0 set threshold
    always_comb begin
        for (int f = 0; f < NUM_FLEX; f++) begin
            flex_exp[f] = |(notify_out & fmask_q[f]);
        end
        set_thr = (pll_cfg_in[0].ll_set_sel > 4'h9) ? 16'h9c40
                : LL_SET_TBL[pll_cfg_in[0].ll_set_sel];
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    sequence ll_trip;
        freq_err_in[0] > set_thr;
    endsequence
    sequence ll_release;
        $fell(status_out[4]);
    endsequence
    notify_sticky_a: assert property (
        ((($past(notify_out) & ~$past(notify_clr_in)) & ~notify_out) == '0))
        else $error("sticky bit dropped");
    notify_enable_a: assert property (
        ((notify_out & ~$past(notify_out) & ~$past(notify_en_in)) == '0))
        else $error("disabled bit captured");
    irq_level_a: assert property (
        fault_irq_n_out == !(|(notify_out & imask_q)))
        else $error("fault pin wrong");
    flex_or_a: assert property (flex_pin_out == flex_exp)
        else $error("flex pin wrong");
    lock_set_a: assert property (ll_trip |-> ##[1:3] status_out[4])
        else $error("lock loss not raised");
    lock_settle_a: assert property (
        ll_release |-> $past(freq_err_in[0], 3) < LL_CLR_TBL[pll_cfg_in[0].ll_clr_sel])
        else $error("lock loss dropped early");
    manual_sel_a: assert property (
        pll_cfg_in[1].manual && $stable(pll_cfg_in[1])
        |=> sel_out[1] == $past(pll_cfg_in[1].man_sel))
        else $error("manual choice ignored");
    switch_cause_a: assert property (
        switch_pulse_out[0] |-> sel_out[0] != $past(sel_out[0]) || $fell(holdover_out[0]))
        else $error("switch pulse without cause");
endmodule
bind rms_ref_monitor rms_ref_watch #(.NUM_FLEX(NUM_FLEX)) i_watch (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .pll_cfg_in(pll_cfg_in),
    .freq_err_in(freq_err_in), .notify_en_in(notify_en_in), .notify_clr_in(notify_clr_in),
    .flex_mask_in(flex_mask_in), .irq_mask_in(irq_mask_in), .status_out(status_out),
    .notify_out(notify_out), .flex_pin_out(flex_pin_out), .fault_irq_n_out(fault_irq_n_out),
    .sel_out(sel_out), .holdover_out(holdover_out), .switch_pulse_out(switch_pulse_out));

// file: verification/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module tb_top;
    import rms_pkg::*;
    localparam int NF = 2;
    logic                       clk_sys_in = 1'b0;
    logic                       resetn_in = 1'b0;
    logic                       count_on = 1'b0;
    logic [NUM_IN-1:0]          run = '1;
    logic [NUM_IN-1:0]          drift = '0;
    logic [NUM_IN-1:0]          ref_clk, pulse;
    rms_in_cfg_t [NUM_IN-1:0]   in_cfg;
    rms_pll_cfg_t [NUM_PLL-1:0] pll_cfg;
    logic [NUM_PLL-1:0][15:0]   ferr = '0;
    logic [NUM_DEF-1:0]         en = 8'hf7;
    logic [NUM_DEF-1:0]         clr_req = '0;
    logic [NUM_DEF-1:0]         irq_mask, clr, status, notify;
    logic [NF-1:0][NUM_DEF-1:0] fmask;
    logic [NF-1:0]              flex;
    logic                       irq_n;
    logic [NUM_PLL-1:0][1:0]    sel;
    logic [NUM_PLL-1:0]         hold, swp;
    rms_sw_t [NUM_PLL-1:0]      swc;
    logic [67:0]                exp_q[$];
    int                         fail_count = 0;
    int                         checks_done = 0;
    int                         pc0 = 0, pc1 = 0, ns = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    rms_ref_src i_src (.clk_in(clk_sys_in), .run_in(run), .clr_req_in(clr_req),
        .ref_clk_out(ref_clk), .notify_clr_out(clr));
    rms_ref_monitor #(.NUM_FLEX(NF), .VAL_CYC_0(20), .VAL_CYC_1(40), .VAL_CYC_2(60),
        .VAL_CYC_3(80)) i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .ref_clk_in(ref_clk), .in_cfg_in(in_cfg), .freq_drift_flag_in(drift),
        .pll_cfg_in(pll_cfg), .freq_err_in(ferr), .notify_en_in(en), .notify_clr_in(clr),
        .flex_mask_in(fmask), .irq_mask_in(irq_mask), .prediv_pulse_out(pulse),
        .status_out(status), .notify_out(notify), .flex_pin_out(flex),
        .fault_irq_n_out(irq_n), .sel_out(sel), .holdover_out(hold),
        .switch_pulse_out(swp), .sw_ctrl_out(swc));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [31:0] observe(input logic [3:0] id);
        case (id)
            4'h0: return 32'(status);
            4'h1: return 32'(notify);
            4'h2: return 32'(irq_n);
            4'h3: return 32'(flex);
            4'h4: return 32'(sel);
            4'h5: return 32'(hold);
            4'h6: return 32'(swc[0]);
            4'h7: return 32'(pc0 inside {[39:41]} && pc1 inside {[9:11]});
            default: return 32'(ns);
        endcase
    endfunction
    task automatic note(input logic [3:0] id, input logic [31:0] want,
                        input logic [31:0] mask = 32'hffffffff);
        exp_q.push_back({id, mask, want & mask});
    endtask
    task automatic note_pins(input logic [7:0] n);
        note(4'h1, 32'(n));
        note(4'h2, 32'(~|(n & irq_mask)));
        for (int f = 0; f < NF; f++) begin
            note(4'h3, 32'(|(n & fmask[f])) << f, 32'h1 << f);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic end_sim;
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // oldest notes compared once outputs have settled
    always @(negedge clk_sys_in) begin
        while (exp_q.size() > 0) begin
            logic [67:0] e;
            e = exp_q.pop_front();
            check(observe(e[67:64]) & e[63:32], e[31:0]);
        end
    end
    // pulses counted inside the measuring window
    always @(posedge clk_sys_in) begin
        if (count_on) begin
            pc0 += int'(pulse[0]);
            pc1 += int'(pulse[1]);
            ns += int'(swp[0]);
        end
    end
    // watchdog
    initial begin
        cyc(5000);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(44993));
        irq_mask = 8'($urandom());
        fmask = 16'($urandom());
        for (int k = 0; k < NUM_IN; k++) begin
            in_cfg[k] = '{1'b1, 16'h4, 24'ha, 8'h2, 8'h1, 2'(k), 1'b0};
            pll_cfg[k] = '{1'b0, 2'h0, 8'he4, 2'h3, '0, 4'h2, 2'h1, 32'h8};
        end
        in_cfg[1] = '{1'b0, 16'h4, 24'h28, 8'h2, 8'h1, 2'h1, 1'b0};
        pll_cfg[1].manual = 1'b1;
        pll_cfg[1].man_sel = 2'h2;
        pll_cfg[2].prio = 8'h1b;
        pll_cfg[2].num_spare = 2'h0;
        pll_cfg[3].num_spare = 2'h1;
        cyc(16);
        resetn_in <= 1'b1;
        cyc(60);
        note(4'h0, 32'h0);
        note_pins(8'h0);
        note(4'h4, 32'h38);
        note(4'h6, 32'h0);
        count_on <= 1'b1;
        cyc(320);
        count_on <= 1'b0;
        cyc(1);
        note(4'h7, 32'h1);
        // first choice lost: pll 0 and pll 3 move to their spare
        count_on <= 1'b1;
        run <= 4'b1110;
        cyc(60);
        count_on <= 1'b0;
        cyc(1);
        note(4'h0, 32'h01);
        note(4'h4, 32'h79);
        note(4'h8, 32'h1);
        clr_req <= 8'h01;
        cyc(3);
        clr_req <= 8'h00;
        cyc(3);
        note_pins(8'h01);
        // spares run out for pll 2 and pll 3, disabled notify bit 3 stays low
        run <= 4'b0100;
        cyc(140);
        note(4'h0, 32'h0b);
        note_pins(8'h03);
        note(4'h4, 32'h7a);
        note(4'h5, 32'hc);
        // recovery must stay clean for each input's own wait
        run <= 4'b1111;
        cyc(12);
        note(4'h0, 32'h0b);
        // a short dropout of input 3 restarts its wait
        run <= 4'b0111;
        cyc(16);
        run <= 4'b1111;
        cyc(24);
        note(4'h0, 32'h08, 32'h09);
        cyc(50);
        note(4'h0, 32'h08, 32'h08);
        cyc(50);
        note(4'h0, 32'h0);
        note_pins(8'h03);
        note(4'h4, 32'h38);
        note(4'h5, 32'h0);
        clr_req <= 8'hff;
        cyc(3);
        clr_req <= 8'h00;
        cyc(3);
        note_pins(8'h00);
        // lock loss with hysteresis and settling on pll 0
        ferr[0] <= LL_SET_TBL[2];
        cyc(10);
        note(4'h0, 32'h0);
        ferr[0] <= LL_SET_TBL[2] + 16'h1;
        cyc(10);
        note_pins(8'h10);
        ferr[0] <= 16'ha;
        cyc(30);
        note(4'h0, 32'h10);
        ferr[0] <= 16'h3;
        cyc(4);
        note(4'h0, 32'h10);
        cyc(20);
        note(4'h0, 32'h0);
        // every set threshold on pll 2, at and just past the limit,
        // and one choice past the table that takes the widest
        for (int s = 0; s < 11; s++) begin
            logic [15:0] thr;
            thr = LL_SET_TBL[(s > 9) ? 9 : s];
            pll_cfg[2].ll_set_sel <= 4'(s);
            ferr[2] <= thr;
            cyc(6);
            note(4'h0, 32'h0, 32'h40);
            ferr[2] <= thr + 16'h1;
            cyc(6);
            note(4'h0, 32'h40, 32'h40);
            ferr[2] <= 16'h0;
            cyc(20);
        end
        // drift counted as loss; each switching style latched at the switch
        in_cfg[0].drift_or <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pll_cfg[0].sw <= rms_sw_t'({i[0], i[1:0], i[1], i[1:0]});
            drift[0] <= ~drift[0];
            cyc(6);
            note(4'h4, 32'(i % 2 == 0), 32'h3);
            note(4'h6, 32'({i[0], i[1:0], i[1], i[1:0]}));
        end
        cyc(2);
        end_sim();
    end
endmodule
